// [hdl/art_pkg.sv]
// Purpose: Shared constants for the auto-reload timer/counter block
// Assumes: Registers are 8 bits wide, one per aligned 32-bit word
// Notes: Byte address of a register is four times its index
package art_pkg;

    // Register indices (byte address = index * 4)
    localparam logic [7:0] ART_IDX_CTRL = 8'h88;
    localparam logic [7:0] ART_IDX_CNT_LO = 8'h8A;
    localparam logic [7:0] ART_IDX_CNT_HI = 8'h8C;
    localparam logic [7:0] ART_IDX_RLD_HI = 8'h8D;
    localparam logic [7:0] ART_IDX_RLD_LO = 8'h90;
    localparam logic [7:0] ART_IDX_IRQ_STAT = 8'h91;
    localparam logic [7:0] ART_IDX_IRQ_MASK = 8'h92;

    // Control register bit positions
    localparam int ART_CB_GATE = 7;
    localparam int ART_CB_SRC = 6;
    localparam int ART_CB_OVF = 5;
    localparam int ART_CB_RUN = 4;
    localparam int ART_CB_A_FLAG = 3;
    localparam int ART_CB_A_TYPE = 2;
    localparam int ART_CB_B_FLAG = 1;
    localparam int ART_CB_B_TYPE = 0;

    // Interrupt status and mask bit positions
    localparam int ART_IB_OVF = 0;
    localparam int ART_IB_A = 1;
    localparam int ART_IB_B = 2;

    // Reset values
    localparam logic [7:0] ART_RST_BYTE = 8'h00;
    localparam logic [2:0] ART_RST_IRQ = 3'h0;

    // Machine cycle timing: twelve clocks per cycle
    localparam logic [3:0] ART_PH_LAST = 4'hB;
    localparam logic [3:0] ART_PH_SAMPLE = 4'h6;

    // AXI responses
    localparam logic [1:0] ART_RESP_OKAY = 2'h0;
    localparam logic [1:0] ART_RESP_DECERR = 2'h3;

endpackage

// [hdl/art_sync.sv]
// Purpose: Two-flop synchroniser for asynchronous pin levels
// Assumes: Inputs are slow levels from outside the clock domain
// Notes: First stage is read only by the second stage
module art_sync
    import art_pkg::*;
#(
    parameter int WIDTH = 3
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta;

    // Two stages, reset to the idle high pin level so no false edge follows reset
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta <= '1;
            sync_out <= '1;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end

endmodule

// [hdl/art_timebase.sv]
// Purpose: Machine-cycle phase counter, twelve clocks per cycle
// Assumes: Runs on every rising edge of the system clock
// Notes: Gives the end-of-cycle and pin-sample points
module art_timebase
    import art_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // Phase outputs
    output logic [3:0] phase_out,
    output logic cycle_end_out,
    output logic sample_out
);

    // Phase wraps after the last of twelve
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            phase_out <= 4'h0;
        end else if (phase_out == ART_PH_LAST) begin
            phase_out <= 4'h0;
        end else begin
            phase_out <= phase_out + 4'h1;
        end
    end

    // Decoded points within the cycle
    assign cycle_end_out = (phase_out == ART_PH_LAST);
    assign sample_out = (phase_out == ART_PH_SAMPLE);

endmodule

// [hdl/art_timer.sv]
// Purpose: 16-bit auto-reload timer/counter with external interrupt flags
// Assumes: AXI4-Lite slave, 8-bit registers in the low byte lane
// Notes: Pins pass two flops before use; outputs come from flops
//
// Behaviour
// - The count advances once per twelve clocks or once per external count event.
// - In counter mode the external count pin is sampled once per cycle at state four phase one.
// - Control bit 6 set counts external events, clear counts the divided clock.
// - With control bit 7 set counting also needs the interrupt-a pin high.
// - Control bit 4 is the run bit; clear holds the count.
// - The count is a 16-bit pair of high and low bytes incremented as one value.
// - On overflow the pair loads from the reload bytes, which stay unchanged.
// - Overflow sets control bit 5, which requests an interrupt when enabled.
// - The overflow flag clears when the handler is entered and on reset.
// - Bits 3 to 0 hold flag a, type a, flag b, type b in that order.
// - A type bit of 1 makes the flag edge set, 0 makes the input level sensitive.
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
module art_timer
    import art_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // AXI4-Lite write address and data
    input wire logic [11:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    // AXI4-Lite read
    input wire logic [11:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // Pins
    input wire logic external_count_pin_in,
    input wire logic ext_int_a_pin_in,
    input wire logic ext_int_b_pin_in,
    // Handler entry: bit 0 overflow, bit 1 flag a, bit 2 flag b
    input wire logic [2:0] vector_ack_in,
    // Interrupt
    output logic irq_out
);

    // Register index is mapped
    function automatic logic is_mapped(input logic [7:0] idx);
        is_mapped = (idx == ART_IDX_CTRL) || (idx == ART_IDX_CNT_LO) ||
                    (idx == ART_IDX_CNT_HI) || (idx == ART_IDX_RLD_HI) ||
                    (idx == ART_IDX_RLD_LO) || (idx == ART_IDX_IRQ_STAT) ||
                    (idx == ART_IDX_IRQ_MASK);
    endfunction

    // Next value of an external interrupt flag; a set beats any clear
    function automatic logic next_ext_flag(input logic flag, input logic edge_type,
                                           input logic fall, input logic low,
                                           input logic wr, input logic wbit,
                                           input logic ack);
        logic kept;
        kept = wr ? wbit : (flag && !ack);
        if (edge_type) begin
            next_ext_flag = fall || kept;
        end else begin
            next_ext_flag = low;
        end
    endfunction

    logic [3:0] phase;
    logic cycle_end;
    logic sample_pt;
    logic [2:0] pins_s;
    logic cnt_pin_s;
    logic pin_a_s;
    logic pin_b_s;
    logic cnt_last;
    logic a_prev;
    logic b_prev;
    logic [7:0] cfg;
    logic ovf_flag;
    logic a_flag;
    logic b_flag;
    logic [15:0] count;
    logic [7:0] rld_lo;
    logic [7:0] rld_hi;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_idx;
    logic [7:0] w_data;
    logic w_lane;
    logic wr_fire;
    logic pin_event;
    logic gate_ok;
    logic count_en;
    logic ovf_evt;
    logic wr_ctrl;
    logic wr_lo;
    logic wr_hi;
    logic fall_a;
    logic fall_b;
    logic [7:0] ctrl_view;
    logic [31:0] rd_word;
    logic [7:0] ar_idx;

    art_timebase u_timebase (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .phase_out(phase),
        .cycle_end_out(cycle_end),
        .sample_out(sample_pt)
    );

    art_sync #(.WIDTH(3)) u_sync (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .async_in({ext_int_b_pin_in, ext_int_a_pin_in, external_count_pin_in}),
        .sync_out(pins_s)
    );

    assign cnt_pin_s = pins_s[0];
    assign pin_a_s = pins_s[1];
    assign pin_b_s = pins_s[2];

    // Write strobes, taken when address and data are both held
    assign wr_fire = aw_held && w_held && !s_axi_bvalid_out;
    assign wr_ctrl = wr_fire && w_lane && (aw_idx == ART_IDX_CTRL);
    assign wr_lo = wr_fire && w_lane && (aw_idx == ART_IDX_CNT_LO);
    assign wr_hi = wr_fire && w_lane && (aw_idx == ART_IDX_CNT_HI);

    // Count qualification: source, run bit and gate
    assign pin_event = sample_pt && cnt_last && !cnt_pin_s;
    assign gate_ok = !cfg[ART_CB_GATE] || pin_a_s;
    assign count_en = cfg[ART_CB_RUN] && gate_ok &&
                      (cfg[ART_CB_SRC] ? pin_event : cycle_end);
    assign ovf_evt = count_en && (&count);

    // Falling edges on the interrupt pins
    assign fall_a = a_prev && !pin_a_s;
    assign fall_b = b_prev && !pin_b_s;

    // Count pin sampled once per machine cycle
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_last <= 1'b0;
        end else if (sample_pt) begin
            cnt_last <= cnt_pin_s;
        end
    end

    // Previous interrupt pin levels
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            a_prev <= 1'b1;
            b_prev <= 1'b1;
        end else begin
            a_prev <= pin_a_s;
            b_prev <= pin_b_s;
        end
    end

    // Software-held control bits; flag bits live apart
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cfg <= ART_RST_BYTE;
        end else if (wr_ctrl) begin
            cfg <= w_data;
        end
    end

    // Overflow flag: set wins over handler entry and software write
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ovf_flag <= 1'b0;
        end else if (ovf_evt) begin
            ovf_flag <= 1'b1;
        end else if (wr_ctrl) begin
            ovf_flag <= w_data[ART_CB_OVF];
        end else if (vector_ack_in[0]) begin
            ovf_flag <= 1'b0;
        end
    end

    // External interrupt flags, edge or level
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            a_flag <= 1'b0;
            b_flag <= 1'b0;
        end else begin
            a_flag <= next_ext_flag(a_flag, cfg[ART_CB_A_TYPE], fall_a, !pin_a_s,
                                    wr_ctrl, w_data[ART_CB_A_FLAG], vector_ack_in[1]);
            b_flag <= next_ext_flag(b_flag, cfg[ART_CB_B_TYPE], fall_b, !pin_b_s,
                                    wr_ctrl, w_data[ART_CB_B_FLAG], vector_ack_in[2]);
        end
    end

    // Count pair: increment, reload on overflow, software writes last
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count <= {ART_RST_BYTE, ART_RST_BYTE};
        end else begin
            if (ovf_evt) begin
                count <= {rld_hi, rld_lo};
            end else if (count_en) begin
                count <= count + 16'h0001;
            end
            if (wr_lo) begin
                count[7:0] <= w_data;
            end
            if (wr_hi) begin
                count[15:8] <= w_data;
            end
        end
    end

    // Reload bytes change only by software
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rld_lo <= ART_RST_BYTE;
            rld_hi <= ART_RST_BYTE;
        end else if (wr_fire && w_lane) begin
            if (aw_idx == ART_IDX_RLD_LO) begin
                rld_lo <= w_data;
            end
            if (aw_idx == ART_IDX_RLD_HI) begin
                rld_hi <= w_data;
            end
        end
    end

    // Sticky interrupt status, write one to clear, events win
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_stat <= ART_RST_IRQ;
        end else begin
            irq_stat <= (irq_stat & ~((wr_fire && w_lane && aw_idx == ART_IDX_IRQ_STAT) ?
                        w_data[2:0] : 3'h0)) |
                        {fall_b && cfg[ART_CB_B_TYPE], fall_a && cfg[ART_CB_A_TYPE], ovf_evt};
        end
    end

    // Interrupt mask
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_mask <= ART_RST_IRQ;
        end else if (wr_fire && w_lane && aw_idx == ART_IDX_IRQ_MASK) begin
            irq_mask <= w_data[2:0];
        end
    end

    // Interrupt output, high while an unmasked status bit is set
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(irq_stat & irq_mask);
        end
    end

    // AXI write channels: address and data taken in either order
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_idx <= 8'h00;
            w_data <= 8'h00;
            w_lane <= 1'b0;
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out <= 1'b1;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= ART_RESP_OKAY;
        end else begin
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_held <= 1'b1;
                aw_idx <= s_axi_awaddr_in[9:2];
                s_axi_awready_out <= 1'b0;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata_in[7:0];
                w_lane <= s_axi_wstrb_in[0];
                s_axi_wready_out <= 1'b0;
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out <= is_mapped(aw_idx) ? ART_RESP_OKAY : ART_RESP_DECERR;
            end
            if (s_axi_bvalid_out && s_axi_bready_in) begin
                s_axi_bvalid_out <= 1'b0;
                s_axi_awready_out <= 1'b1;
                s_axi_wready_out <= 1'b1;
            end
        end
    end

    // Control register view in its documented layout
    assign ctrl_view = {cfg[ART_CB_GATE], cfg[ART_CB_SRC], ovf_flag, cfg[ART_CB_RUN],
                        a_flag, cfg[ART_CB_A_TYPE], b_flag, cfg[ART_CB_B_TYPE]};

    // Read data selection
    assign ar_idx = s_axi_araddr_in[9:2];
    always_comb begin
        rd_word = 32'h0000_0000;
        case (ar_idx)
            ART_IDX_CTRL: rd_word[7:0] = ctrl_view;
            ART_IDX_CNT_LO: rd_word[7:0] = count[7:0];
            ART_IDX_CNT_HI: rd_word[7:0] = count[15:8];
            ART_IDX_RLD_HI: rd_word[7:0] = rld_hi;
            ART_IDX_RLD_LO: rd_word[7:0] = rld_lo;
            ART_IDX_IRQ_STAT: rd_word[2:0] = irq_stat;
            ART_IDX_IRQ_MASK: rd_word[2:0] = irq_mask;
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // AXI read channel: answer one cycle after the address is taken
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_axi_arready_out <= 1'b1;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h0000_0000;
            s_axi_rresp_out <= ART_RESP_OKAY;
        end else begin
            if (s_axi_arvalid_in && s_axi_arready_out) begin
                s_axi_arready_out <= 1'b0;
                s_axi_rvalid_out <= 1'b1;
                s_axi_rdata_out <= rd_word;
                s_axi_rresp_out <= is_mapped(ar_idx) ? ART_RESP_OKAY : ART_RESP_DECERR;
            end else if (s_axi_rvalid_out && s_axi_rready_in) begin
                s_axi_rvalid_out <= 1'b0;
                s_axi_arready_out <= 1'b1;
            end
        end
    end

    // Timer mode counts only at the end of a machine cycle
    property p_timer_tick;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (count_en && !cfg[ART_CB_SRC]) |-> (phase == ART_PH_LAST);
    endproperty
    a_timer_tick: assert property (p_timer_tick)
        else $error("timer mode counted off the cycle end");

    // External events occur only at the sample point
    property p_sample_point;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        pin_event |-> (phase == ART_PH_SAMPLE);
    endproperty
    a_sample_point: assert property (p_sample_point)
        else $error("count pin event outside the sample point");

    // Counter mode ignores cycle ends without a pin event
    property p_counter_src;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (cfg[ART_CB_SRC] && cycle_end && !pin_event && !wr_lo && !wr_hi) |=> $stable(count);
    endproperty
    a_counter_src: assert property (p_counter_src)
        else $error("counter mode advanced without a pin event");

    // Gate low stops counting
    property p_gate;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (cfg[ART_CB_GATE] && !pin_a_s) |-> !count_en;
    endproperty
    a_gate: assert property (p_gate)
        else $error("counted while gated off");

    // Run bit clear holds the count
    property p_hold;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (!cfg[ART_CB_RUN] && !wr_lo && !wr_hi) |=> (count == $past(count));
    endproperty
    a_hold: assert property (p_hold)
        else $error("count moved with run bit clear");

    // Increment by exactly one
    property p_incr;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (count_en && !(&count) && !wr_lo && !wr_hi) |=> (count == $past(count) + 16'h0001);
    endproperty
    a_incr: assert property (p_incr)
        else $error("count did not advance by one");

    // Overflow reloads and sets the flag in the same step
    property p_reload;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (ovf_evt && !wr_lo && !wr_hi) |=> (count == {$past(rld_hi), $past(rld_lo)}) && ovf_flag;
    endproperty
    a_reload: assert property (p_reload)
        else $error("overflow did not reload and flag");

    // Handler entry clears the overflow flag
    property p_ack_clear;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (vector_ack_in[0] && !ovf_evt && !wr_ctrl) |=> !ovf_flag;
    endproperty
    a_ack_clear: assert property (p_ack_clear)
        else $error("overflow flag not cleared on handler entry");

    // Unmasked overflow status raises the interrupt one cycle later
    property p_irq;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (irq_stat[ART_IB_OVF] && irq_mask[ART_IB_OVF]) |=> irq_out;
    endproperty
    a_irq: assert property (p_irq)
        else $error("overflow interrupt not raised");

    // Edge-type flag set by a falling edge
    property p_edge_flag;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (fall_a && cfg[ART_CB_A_TYPE]) |=> a_flag && irq_stat[ART_IB_A];
    endproperty
    a_edge_flag: assert property (p_edge_flag)
        else $error("edge on pin a did not set its flag");

endmodule

// [tb/art_pin_model.sv]
// Purpose: Drives the external count pin with a burst of slow pulses
// Assumes: Each level lasts 30 clocks, longer than one 12-clock machine cycle
// Notes: Pin idles high; each pulse is a low half then a high half
module art_pin_model (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // Burst request
    input wire logic [7:0] pulse_count_in,
    input wire logic go_in,
    // Pin and status
    output logic count_pin_out,
    output logic done_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] left;
    logic [5:0] tick;
    // Pulse sequencer; levels held long enough to be seen at two sample points
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            left <= 8'h00;
            tick <= 6'h00;
            count_pin_out <= 1'b1;
        end else if (go_in) begin
            left <= pulse_count_in;
            tick <= 6'h00;
        end else if (left != 8'h00) begin
            tick <= (tick == 6'h3B) ? 6'h00 : tick + 6'h01;
            count_pin_out <= (tick < 6'h1E) ? 1'b0 : 1'b1;
            if (tick == 6'h3B) left <= left - 8'h01;
        end
    end
    // Burst finished
    assign done_out = (left == 8'h00);
endmodule

// [tb/auto_reload_timer_counter16_bench.sv]
// Purpose: Self-checking bench for the auto-reload timer/counter
// Assumes: One AXI4-Lite access at a time, tasks start just after an edge
// Notes: Count windows span whole 12-clock cycles so counts are exact
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module auto_reload_timer_counter16_bench
    import art_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // Stimulus and observed signals
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
    logic pin_a = 1'b1, pin_b = 1'b1, go = 1'b0;
    logic [2:0] vack = 3'h0;
    logic [7:0] pulses = 8'h00;
    logic awready, wready, bvalid, arready, rvalid, irq, cnt_pin, done;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int bad_count = 0;
    int num_checks = 0;
    logic [7:0] idx_list [7] = '{ART_IDX_CTRL, ART_IDX_CNT_LO, ART_IDX_CNT_HI, ART_IDX_RLD_HI,
        ART_IDX_RLD_LO, ART_IDX_IRQ_STAT, ART_IDX_IRQ_MASK};
    // Clock
    always #2.5 clk_sys_in = ~clk_sys_in;
    art_timer u_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(brdy), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rrdy), .external_count_pin_in(cnt_pin),
        .ext_int_a_pin_in(pin_a), .ext_int_b_pin_in(pin_b), .vector_ack_in(vack),
        .irq_out(irq));
    art_pin_model u_pins (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .pulse_count_in(pulses), .go_in(go), .count_pin_out(cnt_pin), .done_out(done));
    // Verdict and end of run
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Register write, both channels offered together
    task automatic wr(input logic [7:0] idx, input logic [7:0] d,
            input logic [1:0] er = ART_RESP_OKAY);
        int n;
        n = 0;
        awaddr <= {2'h0, idx, 2'h0};
        wdata <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        brdy <= 1'b1;
        do begin
            @(posedge clk_sys_in);
            n++;
            if (awv && awready) awv <= 1'b0;
            if (wv && wready) wv <= 1'b0;
        end while (!bvalid && n < 50);
        if (n >= 50) bad_count++;
        `CHK("bresp", er, bresp)
        brdy <= 1'b0;
        @(posedge clk_sys_in);
    endtask
    // Register read and compare
    task automatic rc(input string nm, input logic [7:0] idx, input logic [7:0] e,
            input logic [1:0] er = ART_RESP_OKAY);
        int n;
        n = 0;
        araddr <= {2'h0, idx, 2'h0};
        arv <= 1'b1;
        rrdy <= 1'b1;
        do begin
            @(posedge clk_sys_in);
            n++;
            if (arv && arready) arv <= 1'b0;
        end while (!rvalid && n < 50);
        if (n >= 50) bad_count++;
        `CHK("rresp", er, rresp)
        `CHK(nm, {24'h0, e}, rdata)
        rrdy <= 1'b0;
        @(posedge clk_sys_in);
    endtask
    // Run with a control value for a fixed span, then stop
    task automatic run_window(input logic [7:0] ctrl);
        wr(ART_IDX_CTRL, ctrl);
        repeat (236) @(posedge clk_sys_in);
        wr(ART_IDX_CTRL, 8'h00);
    endtask
    // Handler entry pulse
    task automatic ack(input logic [2:0] v);
        vack <= v;
        @(posedge clk_sys_in);
        vack <= 3'h0;
    endtask
    // Watchdog against a hung handshake or wait
    initial begin
        #200000;
        bad_count++;
        tally_and_finish();
    end
    // Test sequence
    initial begin
        int n;
        repeat (16) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        @(posedge clk_sys_in);
        foreach (idx_list[i]) rc("reset", idx_list[i], 8'h00);
        rc("unmapped", 8'h89, 8'h00, ART_RESP_DECERR);
        wr(8'h89, 8'h55, ART_RESP_DECERR);
        // Divided clock rate and carry into the high byte
        wr(ART_IDX_CNT_LO, 8'hFF);
        wr(ART_IDX_CNT_HI, 8'h00);
        run_window(8'h10);
        rc("cnt_lo", ART_IDX_CNT_LO, 8'h13);
        rc("cnt_hi", ART_IDX_CNT_HI, 8'h01);
        // Gate pin low blocks counting, high lets it run
        pin_a <= 1'b0;
        wr(ART_IDX_CNT_LO, 8'h00);
        wr(ART_IDX_CNT_HI, 8'h00);
        run_window(8'h90);
        rc("gated", ART_IDX_CNT_LO, 8'h00);
        pin_a <= 1'b1;
        run_window(8'h90);
        rc("ungated", ART_IDX_CNT_LO, 8'h14);
        // External pulses counted in counter mode
        wr(ART_IDX_CNT_LO, 8'h00);
        wr(ART_IDX_CTRL, 8'h50);
        pulses <= 8'h05;
        go <= 1'b1;
        @(posedge clk_sys_in);
        go <= 1'b0;
        @(posedge clk_sys_in);
        for (n = 0; n < 1000 && done !== 1'b1; n++) @(posedge clk_sys_in);
        repeat (30) @(posedge clk_sys_in);
        wr(ART_IDX_CTRL, 8'h00);
        rc("events", ART_IDX_CNT_LO, 8'h05);
        // Overflow reload, flag and interrupt
        wr(ART_IDX_RLD_HI, 8'h12);
        wr(ART_IDX_RLD_LO, 8'h34);
        wr(ART_IDX_CNT_LO, 8'hFE);
        wr(ART_IDX_CNT_HI, 8'hFF);
        wr(ART_IDX_IRQ_MASK, 8'h01);
        wr(ART_IDX_CTRL, 8'h10);
        for (n = 0; n < 100 && irq !== 1'b1; n++) @(posedge clk_sys_in);
        `CHK("irq", 1'b1, irq)
        rc("ctrl", ART_IDX_CTRL, 8'h30);
        rc("reloaded", ART_IDX_CNT_HI, 8'h12);
        rc("rld_hi", ART_IDX_RLD_HI, 8'h12);
        rc("rld_lo", ART_IDX_RLD_LO, 8'h34);
        rc("stat", ART_IDX_IRQ_STAT, 8'h01);
        ack(3'h1);
        rc("acked", ART_IDX_CTRL, 8'h10);
        wr(ART_IDX_IRQ_STAT, 8'h01);
        wr(ART_IDX_CTRL, 8'h00);
        `CHK("irq_clr", 1'b0, irq)
        // External interrupt flags, edge and level
        wr(ART_IDX_CTRL, 8'h04);
        wr(ART_IDX_IRQ_MASK, 8'h06);
        pin_a <= 1'b0;
        repeat (8) @(posedge clk_sys_in);
        rc("edge_a", ART_IDX_CTRL, 8'h0C);
        rc("stat_a", ART_IDX_IRQ_STAT, 8'h02);
        `CHK("irq_a", 1'b1, irq)
        ack(3'h2);
        pin_a <= 1'b1;
        rc("ack_a", ART_IDX_CTRL, 8'h04);
        wr(ART_IDX_IRQ_STAT, 8'h02);
        wr(ART_IDX_CTRL, 8'h00);
        pin_b <= 1'b0;
        repeat (8) @(posedge clk_sys_in);
        rc("level_b", ART_IDX_CTRL, 8'h02);
        pin_b <= 1'b1;
        repeat (4) @(posedge clk_sys_in);
        wr(ART_IDX_CTRL, 8'h01);
        pin_b <= 1'b0;
        repeat (8) @(posedge clk_sys_in);
        rc("edge_b", ART_IDX_CTRL, 8'h03);
        rc("stat_b", ART_IDX_IRQ_STAT, 8'h04);
        ack(3'h4);
        rc("ack_b", ART_IDX_CTRL, 8'h01);
        tally_and_finish();
    end
endmodule
